// ==== hbp_consts.vh ====
// Constants for the host bus port: strap codes, window layout, timing counts
`ifndef HBP_CONSTS_VH
`define HBP_CONSTS_VH

// Strap code on {endian_strap, bus_select_straps} that selects big-endian host mode
`define HBP_BIG_ENDIAN_MODE   4'hf
// Value the reserved strap must show at reset sampling
`define HBP_RESERVED_LEVEL    1'b1
// Strap reset values, unused: the captured straps follow the pins while reset is held
`define HBP_STRAP_RST4        4'h0
`define HBP_STRAP_RST1        1'b0

// Address window: 18 address bits; mem_reg_sel_i selects register block (0) or display buffer (1)
`define HBP_ADDR_W            18
`define HBP_DATA_W            16

// Timing: clock period and guaranteed cycle ceiling
`define HBP_CLK_PERIOD_NS     100
`define HBP_MAX_CYCLE_NS      3200
`define HBP_MAX_CYCLE_CNT     (`HBP_MAX_CYCLE_NS / `HBP_CLK_PERIOD_NS)
`define HBP_CNT_W             6
// Last counter value inside the ceiling, sized to the counter (32 cycles, less one)
`define HBP_CYC_LAST          6'h1f

// Read data returned when an internal access times out
`define HBP_TIMEOUT_RDATA     16'hffff

`endif

// ==== hbp_host_port.v ====
// Host bus port: strap capture, bus clock divide, host cycle tracking and wait generation
`default_nettype none
`include "hbp_consts.vh"

module hbp_host_port (
    input  wire                      clk_i,
    input  wire                      sys_rst_i,
    // Configuration straps (pins)
    input  wire [2:0]                bus_select_straps_i,
    input  wire                      endian_strap_i,
    input  wire                      reserved_strap_i,
    input  wire                      hold_polarity_strap_i,
    input  wire                      clock_divide_strap_i,
    // Host bus pins
    input  wire                      cs_n_i,
    input  wire                      mem_reg_sel_i,
    input  wire [`HBP_ADDR_W-1:0]    addr_i,
    input  wire [`HBP_DATA_W-1:0]    data_i,
    input  wire                      low_byte_write_strobe_n_i,
    input  wire                      high_byte_write_strobe_n_i,
    input  wire                      rd_n_i,
    output reg  [`HBP_DATA_W-1:0]    data_o,
    output reg                       data_oe_o,
    output reg                       wait_o,
    // Internal register and display buffer side
    output reg                       reg_req_o,
    output reg                       mem_req_o,
    output reg  [`HBP_ADDR_W-1:0]    int_addr_o,
    output reg  [`HBP_DATA_W-1:0]    int_wdata_o,
    output reg  [1:0]                int_be_o,
    output reg                       int_we_o,
    input  wire                      int_ack_i,
    input  wire [`HBP_DATA_W-1:0]    int_rdata_i,
    // Configuration and status
    output reg                       bus_clk_o,
    output wire                      mode_ok_o,
    output wire                      strap_fault_o,
    output wire                      clk_div2_o,
    output reg                       timeout_o
);

    // ****************************************************************
    // Local states and helpers
    // ****************************************************************
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ACCESS = 2'h1;
    localparam [1:0] ST_DONE   = 2'h2;

    // Byte swap used for both directions in big-endian mode
    function [`HBP_DATA_W-1:0] hbp_swap;
        input [`HBP_DATA_W-1:0] d;
        input                   en;
        begin
            hbp_swap = en ? {d[7:0], d[15:8]} : d;
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam integer SYNC_W = 3 + 4 + 3 + 1 + `HBP_ADDR_W + `HBP_DATA_W + 1;
    wire [SYNC_W-1:0] pins_raw = {bus_select_straps_i, endian_strap_i, reserved_strap_i,
                                  hold_polarity_strap_i, clock_divide_strap_i,
                                  low_byte_write_strobe_n_i, high_byte_write_strobe_n_i,
                                  rd_n_i, mem_reg_sel_i, addr_i, data_i, cs_n_i};
    reg  [SYNC_W-1:0] pins_meta;
    reg  [SYNC_W-1:0] pins_sync;

    // Two stages; only the second stage is read by logic
    always @(posedge clk_i) begin
        pins_meta <= pins_raw;
        pins_sync <= pins_meta;
    end

    wire                   s_cs_n  = pins_sync[0];
    wire [`HBP_DATA_W-1:0] s_data  = pins_sync[`HBP_DATA_W:1];
    wire [`HBP_ADDR_W-1:0] s_addr  = pins_sync[`HBP_DATA_W+`HBP_ADDR_W:`HBP_DATA_W+1];
    wire                   s_mr    = pins_sync[`HBP_DATA_W+`HBP_ADDR_W+1];
    wire                   s_rd_n  = pins_sync[`HBP_DATA_W+`HBP_ADDR_W+2];
    wire                   s_hwe_n = pins_sync[`HBP_DATA_W+`HBP_ADDR_W+3];
    wire                   s_lwe_n = pins_sync[`HBP_DATA_W+`HBP_ADDR_W+4];
    wire [6:0]             s_strap = pins_sync[SYNC_W-1:SYNC_W-7];

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    reg [3:0] mode_strap;
    reg       rsvd_strap;
    reg       pol_strap;
    reg       div_strap;

    // Follows the pins while reset is held, so the value at release is kept;
    // straps are then frozen until the next reset
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            // Kept as {endian, select} so bit 3 is the endian strap
            mode_strap <= {s_strap[3], s_strap[6:4]};
            rsvd_strap <= s_strap[2];
            pol_strap  <= s_strap[1];
            div_strap  <= s_strap[0];
        end
    end

    assign mode_ok_o     = (mode_strap == `HBP_BIG_ENDIAN_MODE);
    assign strap_fault_o = (rsvd_strap != `HBP_RESERVED_LEVEL);
    assign clk_div2_o    = div_strap;
    wire   big_endian    = mode_strap[3];

    // ****************************************************************
    // Bus clock derivation
    // ****************************************************************
    reg bus_phase;

    // Toggle divider for 2:1, toggle on every clock edge for 1:1
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_phase <= 1'b0;
            bus_clk_o <= 1'b0;
        end else begin
            bus_phase <= div_strap ? ~bus_phase : 1'b1;
            // At 2:1 the bus clock only toggles on the second edge of each pair
            bus_clk_o <= (div_strap & ~bus_phase) ? bus_clk_o : ~bus_clk_o;
        end
    end

    // FSM may leave idle only on a tick: every edge at 1:1, every other at 2:1
    wire bus_tick = ~div_strap | bus_phase;

    // ****************************************************************
    // Host cycle state machine
    // ****************************************************************
    reg [1:0]            state;
    reg [1:0]            next_state;
    reg [`HBP_CNT_W-1:0] cyc_cnt;
    reg                  stall;

    wire host_rd    = ~s_cs_n & ~s_rd_n;
    wire host_wr    = ~s_cs_n & (~s_lwe_n | ~s_hwe_n);
    wire host_act   = host_rd | host_wr;
    wire cyc_expire = (cyc_cnt >= `HBP_CYC_LAST);

    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (host_act && mode_ok_o && bus_tick)
                    next_state = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (int_ack_i || cyc_expire)
                    next_state = ST_DONE;
            end
            ST_DONE: begin
                if (!host_act)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State, internal request and host data path
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state       <= ST_IDLE;
            cyc_cnt     <= {`HBP_CNT_W{1'b0}};
            stall       <= 1'b0;
            reg_req_o   <= 1'b0;
            mem_req_o   <= 1'b0;
            int_addr_o  <= {`HBP_ADDR_W{1'b0}};
            int_wdata_o <= {`HBP_DATA_W{1'b0}};
            int_be_o    <= 2'h0;
            int_we_o    <= 1'b0;
            data_o      <= {`HBP_DATA_W{1'b0}};
            data_oe_o   <= 1'b0;
            timeout_o   <= 1'b0;
        end else begin
            state     <= next_state;
            timeout_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cyc_cnt <= {`HBP_CNT_W{1'b0}};
                    if (next_state == ST_ACCESS) begin
                        // Stall the host from the moment the cycle is seen
                        stall       <= 1'b1;
                        reg_req_o   <= ~s_mr;
                        mem_req_o   <= s_mr;
                        int_addr_o  <= s_addr;
                        int_we_o    <= host_wr;
                        int_wdata_o <= hbp_swap(s_data, big_endian);
                        // High strobe carries D15..8; lanes swap in big-endian
                        int_be_o    <= big_endian ? {~s_lwe_n, ~s_hwe_n} : {~s_hwe_n, ~s_lwe_n};
                    end
                end
                ST_ACCESS: begin
                    cyc_cnt <= cyc_cnt + {{(`HBP_CNT_W-1){1'b0}}, 1'b1};
                    if (next_state == ST_DONE) begin
                        reg_req_o <= 1'b0;
                        mem_req_o <= 1'b0;
                        stall     <= 1'b0;
                        timeout_o <= ~int_ack_i;
                        data_o    <= int_ack_i ? hbp_swap(int_rdata_i, big_endian)
                                               : `HBP_TIMEOUT_RDATA;
                        data_oe_o <= ~int_we_o;
                    end
                end
                ST_DONE: begin
                    // Data held until the host drops its strobes
                    if (next_state == ST_IDLE) begin
                        data_oe_o <= 1'b0;
                        int_we_o  <= 1'b0;
                        int_be_o  <= 2'h0;
                    end
                end
                default: begin
                    stall <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Wait pin polarity
    // ****************************************************************
    // Registered so the pin never glitches while the polarity applies
    always @(posedge clk_i) begin
        if (sys_rst_i)
            wait_o <= 1'b1;
        else
            wait_o <= pol_strap ? stall : ~stall;
    end

endmodule // hbp_host_port
`default_nettype wire

// ==== hbp_port_monitor.sv ====
// Assertion checker for the host bus port pins
`default_nettype none
module hbp_port_monitor (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [2:0] bus_select_straps_i,
    input wire logic       endian_strap_i,
    input wire logic       hold_polarity_strap_i,
    input wire logic       clock_divide_strap_i,
    input wire logic       wait_o,
    input wire logic       reg_req_o,
    input wire logic       mem_req_o,
    input wire logic       int_ack_i,
    input wire logic       mode_ok_o,
    input wire logic       clk_div2_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cap;
    wire        req = reg_req_o | mem_req_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Own strap copy, frozen at release so later pin changes cannot leak in
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cap <= {clock_divide_strap_i, hold_polarity_strap_i, endian_strap_i, bus_select_straps_i};
        end
    end
    mode_code_a: assert property (mode_ok_o == (cap[3:0] == 4'hf)) else $error("mode flag");
    div_flag_a: assert property (clk_div2_o == cap[5]) else $error("divide flag");
    refuse_cycle_a: assert property (!mode_ok_o |-> !req) else $error("request in bad mode");
    wait_raise_a: assert property ($rose(req) |-> ##[0:1] wait_o == cap[4]) else $error("no wait");
    wait_hold_a: assert property (req && $past(req, 2) |-> wait_o == cap[4]) else $error("wait gap");
    wait_end_a: assert property (int_ack_i && req |-> ##[1:3] wait_o != cap[4]) else $error("wait stuck");
    cycle_bound_a: assert property ($rose(req) |-> ##[1:34] !req) else $error("cycle too long");
    idle_level_a: assert property (!$past(sys_rst_i) && !req && !$past(req) |-> wait_o != cap[4])
        else $error("idle wait level");
endmodule // hbp_port_monitor
`default_nettype wire

// ==== hbp_host_model.sv ====
// Host processor model driving the port's bus pins
`default_nettype none
module hbp_host_model (
    input  wire logic        clk_i,
    input  wire logic        pol_i,
    input  wire logic        wait_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        oe_i,
    output var  logic        cs_n_o,
    output var  logic        sel_o,
    output var  logic [17:0] addr_o,
    output var  logic [15:0] data_o,
    output var  logic        lo_n_o,
    output var  logic        hi_n_o,
    output var  logic        rd_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last = 16'h0000;
    // Released data lines flip, so a stale value never looks valid
    task automatic idle();
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        lo_n_o = 1'b1;
        hi_n_o = 1'b1;
        data_o = ~last;
    endtask
    initial begin
        sel_o = 1'b0;
        addr_o = 18'h00000;
        idle();
    end
    // One access, pins held until the wait output ends it
    task automatic acc(input logic we, sel, input logic [17:0] a, input logic [15:0] d,
                       input logic [1:0] be_n, output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        cs_n_o = 1'b0;
        sel_o = sel;
        addr_o = a;
        last = we ? d : last;
        data_o = we ? d : ~last;
        {hi_n_o, lo_n_o} = we ? be_n : 2'b11;
        rd_n_o = we;
        while (wait_i !== pol_i && n < 12) begin
            @(posedge clk_i);
            n++;
        end
        ok = (wait_i === pol_i);
        // No fixed wait states: only the port ends the cycle
        while (wait_i === pol_i && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        ok = ok && (wait_i === !pol_i) && (oe_i === !we);
        q = rdata_i;
        #1;
        idle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    // Host without acknowledge: read strobe stands a fixed count, data taken at its end
    task automatic acc_fixed(input logic [17:0] a, input int ws, output logic [15:0] q);
        @(posedge clk_i);
        #1;
        cs_n_o = 1'b0;
        sel_o = 1'b0;
        addr_o = a;
        data_o = ~last;
        {hi_n_o, lo_n_o} = 2'b11;
        rd_n_o = 1'b0;
        repeat (ws) @(posedge clk_i);
        q = rdata_i;
        #1;
        idle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
endmodule // hbp_host_model
`default_nettype wire

// ==== hbp_testbench.sv ====
// Self-checking bench for the host bus port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, sys_rst_i, endian_strap_i, reserved_strap_i, hold_polarity_strap_i;
    logic        clock_divide_strap_i, cs_n_i, mem_reg_sel_i, low_byte_write_strobe_n_i;
    logic        high_byte_write_strobe_n_i, rd_n_i, data_oe_o, wait_o, reg_req_o, mem_req_o, int_we_o;
    logic        int_ack_i = 1'b0, bus_clk_o, mode_ok_o, strap_fault_o, clk_div2_o, timeout_o, ack_en, ok;
    logic [1:0]  int_be_o;
    logic [2:0]  bus_select_straps_i;
    logic [17:0] addr_i, int_addr_o;
    logic [15:0] data_i, data_o, int_wdata_o, q;
    logic [15:0] int_rdata_i = 16'h12a5;
    logic [19:0] seen;
    logic [18:0] seen_ad;
    logic [2:0]  p;
    int          n_mismatch = 0, checked = 0, cyc = 0, n_to = 0;
    hbp_host_port dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_select_straps_i(bus_select_straps_i),
        .endian_strap_i(endian_strap_i), .reserved_strap_i(reserved_strap_i),
        .hold_polarity_strap_i(hold_polarity_strap_i), .clock_divide_strap_i(clock_divide_strap_i),
        .cs_n_i(cs_n_i), .mem_reg_sel_i(mem_reg_sel_i), .addr_i(addr_i), .data_i(data_i),
        .low_byte_write_strobe_n_i(low_byte_write_strobe_n_i),
        .high_byte_write_strobe_n_i(high_byte_write_strobe_n_i),
        .rd_n_i(rd_n_i), .data_o(data_o), .data_oe_o(data_oe_o), .wait_o(wait_o),
        .reg_req_o(reg_req_o), .mem_req_o(mem_req_o), .int_addr_o(int_addr_o), .int_wdata_o(int_wdata_o),
        .int_be_o(int_be_o), .int_we_o(int_we_o), .int_ack_i(int_ack_i), .int_rdata_i(int_rdata_i),
        .bus_clk_o(bus_clk_o), .mode_ok_o(mode_ok_o), .strap_fault_o(strap_fault_o),
        .clk_div2_o(clk_div2_o), .timeout_o(timeout_o));
    hbp_host_model host (.clk_i(clk_i), .pol_i(hold_polarity_strap_i), .wait_i(wait_o), .rdata_i(data_o),
        .oe_i(data_oe_o),
        .cs_n_o(cs_n_i), .sel_o(mem_reg_sel_i), .addr_o(addr_i), .data_o(data_i),
        .lo_n_o(low_byte_write_strobe_n_i), .hi_n_o(high_byte_write_strobe_n_i), .rd_n_o(rd_n_i));
    always #50 clk_i = ~clk_i;
    // Internal side: one-cycle ack per request, recording what it saw
    always @(posedge clk_i) begin
        if (int_ack_i) begin
            seen    <= {reg_req_o, int_we_o, int_be_o, int_wdata_o};
            seen_ad <= {mem_req_o, int_addr_o};
        end
        if (timeout_o) n_to <= n_to + 1;
        int_ack_i <= #1 ack_en & (reg_req_o | mem_req_o) & ~int_ack_i;
    end
    // Hang guard, far above the fewer than 200 cycles the tests take
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [19:0] e, s);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Straps {div, pol, reserved, endian, select} stand through reset
    task automatic rst(input logic [6:0] s);
        {clock_divide_strap_i, hold_polarity_strap_i, reserved_strap_i, endian_strap_i, bus_select_straps_i} = s;
        sys_rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    // Bus clock level at three edges in a row after release
    task automatic clk_pat(output logic [2:0] pat);
        pat[2] = bus_clk_o;
        @(posedge clk_i);
        #1;
        pat[1] = bus_clk_o;
        @(posedge clk_i);
        #1;
        pat[0] = bus_clk_o;
    endtask
    // ****************
    // Test sequence
    // ****************
    initial begin
        ack_en = 1'b1;
        rst(7'b0111111);
        chk("mode", 1, mode_ok_o);
        chk("fault", 0, strap_fault_o);
        chk("div", 0, clk_div2_o);
        chk("idle wait", 0, wait_o);
        clk_pat(p);
        chk("bus clk", 3'b101, p);
        {clock_divide_strap_i, endian_strap_i, bus_select_straps_i} = 5'b10000;
        host.acc(1, 0, 18'h00104, 16'h3c7e, 2'b01, q, ok);
        chk("kept mode", 1, mode_ok_o);
        chk("wr ok", 1, ok);
        chk("wr", 12'hd3c, {seen[19:16], seen[7:0]});
        chk("wr addr", {1'b0, 18'h00104}, seen_ad);
        host.acc(0, 1, 18'h20010, 16'h0000, 2'b11, q, ok);
        chk("rd ok", 1, ok);
        chk("rd", 16'ha512, q);
        chk("rd target", 2'b00, seen[19:18]);
        chk("rd addr", {1'b1, 18'h20010}, seen_ad);
        ack_en = 1'b0;
        host.acc(0, 0, 18'h00008, 16'h0000, 2'b11, q, ok);
        chk("to ok", 1, ok);
        chk("to data", 16'hffff, q);
        chk("timeouts", 1, n_to);
        ack_en = 1'b1;
        host.acc_fixed(18'h00040, 6, q);
        chk("fixed rd", 16'ha512, q);
        rst(7'b1011111);
        chk("div", 1, clk_div2_o);
        chk("idle wait", 1, wait_o);
        clk_pat(p);
        chk("bus clk", 3'b011, p);
        host.acc(0, 0, 18'h00020, 16'h0000, 2'b11, q, ok);
        chk("rd ok", 1, ok);
        chk("rd", 16'ha512, q);
        rst(7'b0100111);
        chk("mode", 0, mode_ok_o);
        chk("fault", 1, strap_fault_o);
        host.acc(0, 0, 18'h00020, 16'h0000, 2'b11, q, ok);
        chk("refused", 0, ok);
        end_of_test();
    end
endmodule // testbench
bind hbp_host_port hbp_port_monitor u_mon (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_select_straps_i(bus_select_straps_i),
    .endian_strap_i(endian_strap_i), .hold_polarity_strap_i(hold_polarity_strap_i),
    .clock_divide_strap_i(clock_divide_strap_i), .wait_o(wait_o), .reg_req_o(reg_req_o),
    .mem_req_o(mem_req_o), .int_ack_i(int_ack_i), .mode_ok_o(mode_ok_o), .clk_div2_o(clk_div2_o));
`default_nettype wire
